// ---- adcsp_pkg.sv ----
// Purpose: Shared constants and types for the converter serial port and channel scan block
// Assumes: Master clock equals core_clk; times are counted in master clock periods
// Notes:   Channel codes: 0-7 differential pairs, 8-23 single-ended inputs, 24 up monitors
`default_nettype none

package adcsp_pkg;

	// ---------------------------------------------------------------
	// Timing
	// ---------------------------------------------------------------
	localparam int          CLK_PERIOD_NS     = 25;
	localparam int          IDLE_LIMIT_LONG   = 4096;
	localparam int          IDLE_LIMIT_SHORT  = 256;
	localparam int          IDLE_CNT_W        = 13;
	localparam int          CS_TRISTATE_MAX   = 5;
	localparam int          RESULT_READY_N_PULSE_CLK    = 1;
	localparam int          SCAN_RATE_SPS     = 23700;
	localparam int          SCAN_PASS_US      = 700;

	// ---------------------------------------------------------------
	// Data and channel map
	// ---------------------------------------------------------------
	localparam int          DATA_W            = 24;
	localparam int          BYTE_W            = 8;
	localparam int          NUM_DIFF          = 8;
	localparam int          NUM_SINGLE        = 16;
	localparam int          NUM_MON           = 5;
	localparam int          NUM_CH            = NUM_DIFF + NUM_SINGLE + NUM_MON;
	localparam int          CH_W              = 5;
	localparam logic [4:0]  CH_FIRST_SINGLE   = 5'h08;
	localparam logic [4:0]  CH_FIRST_MON      = 5'h18;

	typedef enum logic [1:0] {
		SRC_DIFF,
		SRC_SINGLE,
		SRC_MONITOR
	} adcsp_src_t;

	typedef enum {
		SEQ_IDLE,
		SEQ_BREAK,
		SEQ_MAKE,
		SEQ_CONV
	} adcsp_seq_t;

	typedef struct packed {
		logic             closed;
		adcsp_src_t       kind;
		logic [CH_W-1:0]  channel;
	} adcsp_mux_t;

endpackage : adcsp_pkg

`default_nettype wire

// ---- adcsp_serial_scan.sv ----
// Purpose: Serial port timing, result-ready signalling and input channel sequencing
// Assumes: core_clk is the master clock; sclk is the host's serial clock, idle between frames
// Notes:   Link logic is cleared asynchronously by chip select high or by an idle timeout
//
// Notes on behaviour
// [RULE1] The serial link logic is reset when sclk holds one level for over 4096 master clocks.
// [RULE2] A select input shortens that idle limit to 256 master clocks.
// [RULE3] The host waits at least 2.5 master clocks from chip select low to the first sclk edge.
// [RULE4] After chip select goes high, the data output is released within 5 master clocks.
// [RULE5] Chip select may stay low for ever and the serial link still works word after word.
// [RULE6] A new result arriving while the old one is unread pulses result-ready high one clock.
// [RULE7] With chip select low, new output data is valid at least half a clock before ready falls.
// [RULE8] One mux mode bit chooses automatic scanning or fixed-channel operation.
// [RULE9] Automatic scanning steps through enabled channels, opening one switch before the next.
// [RULE10] In fixed-channel mode the host supplies the address and only that channel converts.
// [RULE11] The multiplexer routes exactly one source: a single-ended input, a pair or a monitor.
// [RULE12] Scanning adds little overhead so each channel can run at up to 23.7 kSPS.
// [RULE13] Serial input is sampled on rising sclk and serial output changes on falling sclk.
// [RULE14] Result-ready is active low.
// [RULE15] The start input is active high and runs conversions while high.
// [RULE16] After the last enabled channel the scan wraps to the first enabled one.
`default_nettype none

module adcsp_serial_scan (
	input  wire logic                            core_clk,
	input  wire logic                            rst_n,
	input  wire logic                            sclk,
	input  wire logic                            csN,
	input  wire logic                            din,
	output logic                                 doutOut,
	output logic                                 doutOe,
	output logic                                 resultReadyN,
	input  wire logic                            startPin,
	input  wire logic                            muxModeSelect,
	input  wire logic [adcsp_pkg::CH_W-1:0]      fixedChannel,
	input  wire logic [adcsp_pkg::NUM_CH-1:0]    channelEnable,
	input  wire logic                            idleLimitShort,
	input  wire logic                            resultValid,
	input  wire logic [adcsp_pkg::DATA_W-1:0]    resultData,
	output logic [adcsp_pkg::BYTE_W-1:0]         cmdByte,
	output logic                                 cmdValid,
	output logic                                 convStart,
	output adcsp_pkg::adcsp_mux_t                muxSel,
	output logic [adcsp_pkg::NUM_CH-1:0]         muxRoute
);

	// ---------------------------------------------------------------
	// Functions
	// ---------------------------------------------------------------
	function automatic logic [adcsp_pkg::CH_W-1:0] nextEnabled(
		input logic [adcsp_pkg::CH_W-1:0]   cur,
		input logic [adcsp_pkg::NUM_CH-1:0] mask
	);
		logic [adcsp_pkg::CH_W-1:0] res;
		logic                       found;
		int                         idx;
		res = cur;
		found = 1'b0;
		for (int i = 1; i <= adcsp_pkg::NUM_CH; i++) begin
			idx = (int'(cur) + i) % adcsp_pkg::NUM_CH;
			if (!found && mask[idx]) begin
				res = idx[adcsp_pkg::CH_W-1:0];
				found = 1'b1;
			end
		end
		return res;
	endfunction : nextEnabled

	function automatic adcsp_pkg::adcsp_src_t srcKind(input logic [adcsp_pkg::CH_W-1:0] ch);
		adcsp_pkg::adcsp_src_t k;
		if (ch < adcsp_pkg::CH_FIRST_SINGLE) begin
			k = adcsp_pkg::SRC_DIFF;
		end else if (ch < adcsp_pkg::CH_FIRST_MON) begin
			k = adcsp_pkg::SRC_SINGLE;
		end else begin
			k = adcsp_pkg::SRC_MONITOR;
		end
		return k;
	endfunction : srcKind

	// ---------------------------------------------------------------
	// Pin synchronisers
	// ---------------------------------------------------------------
	logic [1:0] sclkSync_q;
	logic       sclkPrev_q;
	logic [1:0] csSync_q;
	logic [1:0] startSync_q;
	logic       rxTgl_q;
	logic       rdTgl_q;
	logic [1:0] rxTglSync_q;
	logic       rxTglSeen_q;
	logic [1:0] rdTglSync_q;
	logic       rdTglSeen_q;

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			sclkSync_q  <= 2'h0;
			sclkPrev_q  <= 1'b0;
			csSync_q    <= 2'h3;
			startSync_q <= 2'h0;
			rxTglSync_q <= 2'h0;
			rxTglSeen_q <= 1'b0;
			rdTglSync_q <= 2'h0;
			rdTglSeen_q <= 1'b0;
		end else begin
			sclkSync_q  <= {sclkSync_q[0], sclk};
			sclkPrev_q  <= sclkSync_q[1];
			csSync_q    <= {csSync_q[0], csN};
			startSync_q <= {startSync_q[0], startPin};
			rxTglSync_q <= {rxTglSync_q[0], rxTgl_q};
			rxTglSeen_q <= rxTglSync_q[1];
			rdTglSync_q <= {rdTglSync_q[0], rdTgl_q};
			rdTglSeen_q <= rdTglSync_q[1];
		end
	end

	// ---------------------------------------------------------------
	// Serial clock idle watchdog
	// ---------------------------------------------------------------
	logic [adcsp_pkg::IDLE_CNT_W-1:0] idleCnt_q, idleCnt_d;
	logic [adcsp_pkg::IDLE_CNT_W-1:0] idleLimit;
	logic                             linkRst_q, linkRst_d;
	logic                             sclkMoved;

	always_comb begin
		idleLimit = idleLimitShort ? adcsp_pkg::IDLE_CNT_W'(adcsp_pkg::IDLE_LIMIT_SHORT)
		                           : adcsp_pkg::IDLE_CNT_W'(adcsp_pkg::IDLE_LIMIT_LONG); // RULE2
		sclkMoved = sclkSync_q[1] ^ sclkPrev_q;
		idleCnt_d = idleCnt_q;
		if (sclkMoved) begin
			idleCnt_d = '0;
		end else if (idleCnt_q != idleLimit) begin
			idleCnt_d = idleCnt_q + 1'b1;
		end
		// One pulse as the level outlasts the limit; sclk is idle, so release is safe
		linkRst_d = !sclkMoved && (idleCnt_q == idleLimit - 1'b1); // RULE1
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			idleCnt_q <= '0;
			linkRst_q <= 1'b1;
		end else begin
			idleCnt_q <= idleCnt_d;
			linkRst_q <= linkRst_d;
		end
	end

	// ---------------------------------------------------------------
	// Link domain: receive on rising sclk, transmit on falling sclk
	// ---------------------------------------------------------------
	logic                              linkClr;
	logic [adcsp_pkg::BYTE_W-1:0]      rxShift_q, rxShift_d;
	logic [2:0]                        rxCnt_q, rxCnt_d;
	logic [adcsp_pkg::BYTE_W-1:0]      rxByte_q, rxByte_d;
	logic                              rxTgl_d;
	logic [4:0]                        txIdx_q, txIdx_d;
	logic                              txBit_q, txBit_d;
	logic                              rdTgl_d;
	logic [adcsp_pkg::DATA_W-1:0]      resHold_q, resHold_d;

	// Chip select high or the idle watchdog restarts the word position
	assign linkClr = csN | linkRst_q; // RULE3

	always_comb begin
		rxShift_d = {rxShift_q[adcsp_pkg::BYTE_W-2:0], din}; // RULE13
		rxCnt_d   = rxCnt_q + 1'b1;
		rxByte_d  = rxByte_q;
		rxTgl_d   = rxTgl_q;
		if (rxCnt_q == 3'h7) begin
			rxByte_d = {rxShift_q[adcsp_pkg::BYTE_W-2:0], din};
			rxTgl_d  = ~rxTgl_q;
		end
	end

	always_ff @(posedge sclk or posedge linkClr) begin
		if (linkClr) begin
			rxShift_q <= '0;
			rxCnt_q   <= 3'h0;
		end else begin
			rxShift_q <= rxShift_d;
			rxCnt_q   <= rxCnt_d;
		end
	end

	// Captured byte and its toggle survive a clear so no event is lost
	always_ff @(posedge sclk or negedge rst_n) begin
		if (!rst_n) begin
			rxByte_q <= '0;
			rxTgl_q  <= 1'b0;
		end else begin
			rxByte_q <= rxByte_d;
			rxTgl_q  <= rxTgl_d;
		end
	end

	// Result word is quasi-static while read: it only changes on a new conversion
	always_comb begin
		txIdx_d = txIdx_q + 1'b1;
		if (txIdx_q == 5'(adcsp_pkg::DATA_W - 1)) begin
			txIdx_d = 5'h00; // RULE5
		end
		txBit_d = resHold_q[adcsp_pkg::DATA_W - 2 - int'(txIdx_q)];
		if (txIdx_q == 5'(adcsp_pkg::DATA_W - 1)) begin
			txBit_d = 1'b0;
		end
	end

	always_ff @(negedge sclk or posedge linkClr) begin
		if (linkClr) begin
			txIdx_q <= 5'h00;
			txBit_q <= 1'b0;
		end else begin
			txIdx_q <= txIdx_d; // RULE13
			txBit_q <= txBit_d;
		end
	end

	always_comb begin
		rdTgl_d = rdTgl_q;
		if (txIdx_q == 5'(adcsp_pkg::DATA_W - 1)) begin
			rdTgl_d = ~rdTgl_q;
		end
	end

	always_ff @(negedge sclk or negedge rst_n) begin
		if (!rst_n) begin
			rdTgl_q <= 1'b0;
		end else begin
			rdTgl_q <= rdTgl_d;
		end
	end

	// ---------------------------------------------------------------
	// Result holding, ready flag and output enable
	// ---------------------------------------------------------------
	logic                         firstBit_q, firstBit_d;
	logic                         ready_q, ready_d;
	logic                         fallPend_q, fallPend_d;
	logic                         doutOe_q, doutOe_d;
	logic [adcsp_pkg::BYTE_W-1:0] cmdByte_q, cmdByte_d;
	logic                         cmdValid_q, cmdValid_d;
	logic                         readDone;

	assign readDone = rdTglSync_q[1] ^ rdTglSeen_q;

	always_comb begin
		resHold_d  = resHold_q;
		firstBit_d = firstBit_q;
		ready_d    = ready_q;
		fallPend_d = 1'b0;
		if (resultValid) begin
			// Data and first output bit update now, ready falls one clock later
			resHold_d  = resultData; // RULE7
			firstBit_d = resultData[adcsp_pkg::DATA_W-1];
			ready_d    = 1'b0;
			fallPend_d = 1'b1;
		end else if (fallPend_q) begin
			ready_d = 1'b1; // RULE14
		end else if (readDone) begin
			ready_d = 1'b0;
		end
		// An unread result forces a one-clock high pulse before the new low
		doutOe_d   = !csSync_q[1]; // RULE4
		cmdValid_d = rxTglSync_q[1] ^ rxTglSeen_q;
		cmdByte_d  = cmdValid_d ? rxByte_q : cmdByte_q;
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			resHold_q  <= '0;
			firstBit_q <= 1'b0;
			ready_q    <= 1'b0;
			fallPend_q <= 1'b0;
			doutOe_q   <= 1'b0;
			cmdByte_q  <= '0;
			cmdValid_q <= 1'b0;
		end else begin
			resHold_q  <= resHold_d;
			firstBit_q <= firstBit_d;
			ready_q    <= ready_d; // RULE6
			fallPend_q <= fallPend_d;
			doutOe_q   <= doutOe_d;
			cmdByte_q  <= cmdByte_d;
			cmdValid_q <= cmdValid_d;
		end
	end

	assign resultReadyN = !ready_q; // RULE14
	assign doutOut      = (txIdx_q == 5'h00) ? firstBit_q : txBit_q;
	assign doutOe       = doutOe_q;
	assign cmdByte      = cmdByte_q;
	assign cmdValid     = cmdValid_q;

	// ---------------------------------------------------------------
	// Channel sequencer
	// ---------------------------------------------------------------
	adcsp_pkg::adcsp_seq_t          seq_q, seq_d;
	logic [adcsp_pkg::CH_W-1:0]     chan_q, chan_d;
	logic                           convStart_q, convStart_d;
	logic                           running;

	assign running = startSync_q[1]; // RULE15

	always_comb begin
		seq_d       = seq_q;
		chan_d      = chan_q;
		convStart_d = 1'b0;
		case (seq_q)
			adcsp_pkg::SEQ_IDLE: begin
				if (running) begin
					chan_d = muxModeSelect ? fixedChannel // RULE8
					                       : nextEnabled(5'(adcsp_pkg::NUM_CH - 1), channelEnable);
					seq_d  = adcsp_pkg::SEQ_BREAK;
				end
			end
			adcsp_pkg::SEQ_BREAK: begin
				// All switches open for this clock before the next one closes
				seq_d = running ? adcsp_pkg::SEQ_MAKE : adcsp_pkg::SEQ_IDLE; // RULE9
			end
			adcsp_pkg::SEQ_MAKE: begin
				convStart_d = 1'b1;
				seq_d       = adcsp_pkg::SEQ_CONV;
			end
			adcsp_pkg::SEQ_CONV: begin
				if (!running) begin
					seq_d = adcsp_pkg::SEQ_IDLE;
				end else if (resultValid) begin
					// Two clocks of overhead per channel keep the scan rate intact
					if (muxModeSelect) begin
						chan_d = fixedChannel; // RULE10
					end else begin
						chan_d = nextEnabled(chan_q, channelEnable); // RULE16
					end
					seq_d = adcsp_pkg::SEQ_BREAK; // RULE12
				end
			end
			default: begin
				seq_d = adcsp_pkg::SEQ_IDLE;
			end
		endcase
		if (chan_d >= 5'(adcsp_pkg::NUM_CH)) begin
			chan_d = chan_q;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			seq_q       <= adcsp_pkg::SEQ_IDLE;
			chan_q      <= '0;
			convStart_q <= 1'b0;
		end else begin
			seq_q       <= seq_d;
			chan_q      <= chan_d;
			convStart_q <= convStart_d;
		end
	end

	// ---------------------------------------------------------------
	// Multiplexer drive
	// ---------------------------------------------------------------
	logic closedNow;

	assign closedNow = (seq_q == adcsp_pkg::SEQ_MAKE) || (seq_q == adcsp_pkg::SEQ_CONV);

	always_comb begin
		muxSel.closed  = closedNow;
		muxSel.kind    = srcKind(chan_q);
		muxSel.channel = chan_q;
		muxRoute       = '0;
		if (closedNow) begin
			muxRoute[chan_q] = 1'b1; // RULE11
		end
	end

	assign convStart = convStart_q;

endmodule : adcsp_serial_scan

`default_nettype wire

// ---- adcsp_serial_scan_assertions.sv ----
// Purpose: Port-level timing checks for the serial scan block
// Assumes: One core_clk domain, rst_n synchronous and active low
// Notes:   Bound to every adcsp_serial_scan instance
`default_nettype none

module adcsp_serial_scan_assertions (
	input wire logic                         core_clk,
	input wire logic                         rst_n,
	input wire logic                         csN,
	input wire logic                         doutOut,
	input wire logic                         doutOe,
	input wire logic                         resultReadyN,
	input wire logic                         muxModeSelect,
	input wire logic [adcsp_pkg::CH_W-1:0]   fixedChannel,
	input wire logic [adcsp_pkg::NUM_CH-1:0] channelEnable,
	input wire logic                         resultValid,
	input wire logic [adcsp_pkg::DATA_W-1:0] resultData,
	input wire logic                         convStart,
	input wire adcsp_pkg::adcsp_mux_t        muxSel,
	input wire logic [adcsp_pkg::NUM_CH-1:0] muxRoute
);
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rst_n);

	sequence s_readyPulse;
		resultReadyN ##1 !resultReadyN;
	endsequence
	sequence s_make;
		!(|muxRoute) ##1 (|muxRoute);
	endsequence

	a_ready_pulse: assert property (resultValid |=> s_readyPulse)
		else $error("result ready pulse wrong");
	a_oe_release: assert property ($rose(csN) |-> ##[1:5] !doutOe)
		else $error("dout not released after deselect");
	a_dout_early: assert property (
		!csN && $fell(resultReadyN) && $past(resultValid, 2) |-> doutOe
			&& doutOut == $past(resultData[23], 2))
		else $error("dout not valid when ready falls");
	a_one_source: assert property (
		$onehot0(muxRoute) && (!(|muxRoute) || muxRoute[muxSel.channel]))
		else $error("route not one source");
	a_break_make: assert property (
		(|muxRoute) && $changed(muxRoute) |-> $past(muxRoute) == '0)
		else $error("switch closed before open");
	a_conv_make: assert property (s_make |-> ##[0:2] convStart)
		else $error("no start after route close");
	a_fixed_chan: assert property (
		muxModeSelect && $stable(fixedChannel) && $rose(|muxRoute)
			|-> muxSel.channel == fixedChannel)
		else $error("fixed channel not used");
	a_scan_enabled: assert property (
		!muxModeSelect && $stable(channelEnable) && $rose(|muxRoute)
			|-> channelEnable[muxSel.channel])
		else $error("scan closed disabled channel");
endmodule : adcsp_serial_scan_assertions

bind adcsp_serial_scan adcsp_serial_scan_assertions u_adcsp_serial_scan_assertions (
	.core_clk, .rst_n, .csN, .doutOut, .doutOe, .resultReadyN, .muxModeSelect,
	.fixedChannel, .channelEnable, .resultValid, .resultData, .convStart, .muxSel, .muxRoute
);

`default_nettype wire

// ---- adcsp_host_model.sv ----
// Purpose: Serial master model on the far side of the link
// Assumes: sclk idles low and only runs inside frames, period 32 ns
// Notes:   din shows the inverse of its last bit once released
`default_nettype none

module adcsp_host_model (
	output logic        sclk,
	output logic        csN,
	output logic        din,
	input  wire logic   doutPin,
	output logic [23:0] rxWord,
	output logic        rxStrobe
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		sclk = 1'b0;
		csN = 1'b1;
		din = 1'b0;
		rxWord = '0;
		rxStrobe = 1'b0;
	end

	// Select stays low across frames until deselect is called
	task automatic select();
		if (csN) begin
			#7 csN = 1'b0;
			#150;
		end
	endtask : select

	task automatic deselect();
		#20 csN = 1'b1;
	endtask : deselect

	task automatic shiftBit(input logic b, output logic r);
		din = b;
		#16 sclk = 1'b1;
		r = doutPin;
		#16 sclk = 1'b0;
	endtask : shiftBit

	task automatic sendByte(input logic [7:0] v);
		logic r;
		select();
		for (int i = 7; i >= 0; i--)
			shiftBit(v[i], r);
		#4 din = ~din;
	endtask : sendByte

	task automatic sendNibble(input logic [3:0] v);
		logic r;
		select();
		for (int i = 3; i >= 0; i--)
			shiftBit(v[i], r);
		#4 din = ~din;
	endtask : sendNibble

	task automatic readWord();
		logic [23:0] w;
		select();
		for (int i = 23; i >= 0; i--)
			shiftBit(1'b0, w[i]);
		#4 din = ~din;
		rxWord = w;
		rxStrobe = 1'b1;
		#1 rxStrobe = 1'b0;
	endtask : readWord
endmodule : adcsp_host_model

`default_nettype wire

// ---- tb.sv ----
// Purpose: Self-checking bench for the serial port and channel scan block
// Assumes: Host model drives the link, bench drives the core side
// Notes:   Expected values travel in queues to monitor processes
`default_nettype none

module tb;
	timeunit 1ns;
	timeprecision 1ps;

	logic core_clk = 1'b0, rst_n = 1'b1, startPin = 1'b0, muxModeSelect = 1'b0;
	logic idleLimitShort = 1'b0, resultValid = 1'b0;
	logic [4:0] fixedChannel = 5'h00;
	logic [28:0] channelEnable = 29'h0;
	logic [23:0] resultData = 24'h0;
	logic sclk, csN, din, doutOut, doutOe, resultReadyN, cmdValid, convStart, rxStrobe;
	logic [7:0] cmdByte;
	logic [23:0] rxWord;
	logic [28:0] muxRoute;
	adcsp_pkg::adcsp_mux_t muxSel;
	wire doutPin = doutOe ? doutOut : 1'b0; // Pull-down when released
	logic [7:0] expCmd[$];
	logic [23:0] expWord[$];
	adcsp_pkg::adcsp_mux_t expMux[$];
	logic [4:0] fixedCodes[3] = '{5'h03, 5'h0f, 5'h1a};
	int errors = 0;
	int n_compared = 0;
	int cycles = 0;
	logic [31:0] rng = 32'he09dfba9;

	adcsp_serial_scan u_adcsp_serial_scan (.core_clk, .rst_n, .sclk, .csN, .din, .doutOut,
		.doutOe, .resultReadyN, .startPin, .muxModeSelect, .fixedChannel, .channelEnable,
		.idleLimitShort, .resultValid, .resultData, .cmdByte, .cmdValid, .convStart,
		.muxSel, .muxRoute);
	adcsp_host_model u_adcsp_host_model (.sclk, .csN, .din, .doutPin, .rxWord, .rxStrobe);

	always #12.5 core_clk = ~core_clk;

	function automatic logic [31:0] rnd();
		rng ^= rng << 13;
		rng ^= rng >> 17;
		rng ^= rng << 5;
		return rng;
	endfunction : rnd

	function automatic logic [4:0] nextEn(input logic [4:0] cur, input logic [28:0] m);
		logic [4:0] c;
		c = cur;
		for (int i = 0; i < 29; i++) begin
			c = (c == 5'h1c) ? 5'h00 : c + 5'h01;
			if (m[c])
				return c;
		end
		return cur;
	endfunction : nextEn

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			errors++;
			$display("BAD %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	task automatic give_verdict();
		$display("compared %0d errors %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : give_verdict

	task automatic clks(input int n);
		repeat (n) @(posedge core_clk);
	endtask : clks

	task automatic giveResult(input logic [23:0] d);
		@(posedge core_clk);
		resultValid <= 1'b1;
		resultData <= d;
		@(posedge core_clk);
		resultValid <= 1'b0;
	endtask : giveResult

	task automatic deselectCheck();
		u_adcsp_host_model.deselect();
		clks(6);
		check("doutOe", 32'(doutOe), 32'h0);
	endtask : deselectCheck

	task automatic wd(input logic s, input logic [3:0] a, input int w, input logic [3:0] b, c);
		idleLimitShort <= s;
		expCmd.push_back(w > (s ? adcsp_pkg::IDLE_LIMIT_SHORT : adcsp_pkg::IDLE_LIMIT_LONG)
			? {b, c} : {a, b});
		clks(2);
		u_adcsp_host_model.sendNibble(a);
		clks(w);
		u_adcsp_host_model.sendNibble(b);
		u_adcsp_host_model.sendNibble(c);
		deselectCheck();
	endtask : wd

	task automatic convert(input logic [4:0] ch, input logic stop);
		adcsp_pkg::adcsp_mux_t m;
		int t;
		m.closed = 1'b1;
		m.channel = ch;
		m.kind = ch < adcsp_pkg::CH_FIRST_SINGLE ? adcsp_pkg::SRC_DIFF : ch <
			adcsp_pkg::CH_FIRST_MON ? adcsp_pkg::SRC_SINGLE : adcsp_pkg::SRC_MONITOR;
		expMux.push_back(m);
		t = 0;
		while (convStart !== 1'b1 && t < 60) begin
			@(posedge core_clk);
			t++;
		end
		if (stop)
			startPin <= 1'b0;
		clks(4);
		giveResult(24'(rnd()));
	endtask : convert

	always @(negedge core_clk) begin
		if (cmdValid === 1'b1)
			check("cmdByte", 32'(cmdByte), 32'(expCmd.pop_front()));
		if (convStart === 1'b1)
			check("muxSel", 32'(muxSel), 32'(expMux.pop_front()));
	end

	always @(posedge rxStrobe)
		check("rxWord", 32'(rxWord), 32'(expWord.pop_front()));

	always @(posedge core_clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			errors++;
			give_verdict();
		end
	end

	initial begin
		logic [7:0] b;
		logic [23:0] d;
		logic [28:0] mask;
		logic [4:0] ch;
		// A real falling edge clears the link-side toggles, which see no sclk in reset
		rst_n <= 1'b0;
		clks(10);
		rst_n <= 1'b1;
		clks(3);
		for (int k = 0; k < 3; k++) begin
			b = 8'(rnd());
			expCmd.push_back(b);
			u_adcsp_host_model.sendByte(b);
			deselectCheck();
		end
		wd(1'b1, 4'ha, 300, 4'h6, 4'h5);
		wd(1'b0, 4'h5, 300, 4'h9, 4'h3);
		wd(1'b0, 4'h7, 4200, 4'hc, 4'h3);
		for (int k = 0; k < 3; k++) begin
			if (k == 2) begin
				giveResult(24'(rnd()));
				clks(10);
			end
			d = 24'(rnd());
			expWord.push_back(d);
			giveResult(d);
			clks(4);
			check("readyN", 32'(resultReadyN), 32'h0);
			repeat (3) expCmd.push_back(8'h00);
			u_adcsp_host_model.readWord();
			clks(8);
			check("readyN", 32'(resultReadyN), 32'h1);
		end
		deselectCheck();
		muxModeSelect <= 1'b1;
		foreach (fixedCodes[i]) begin
			fixedChannel <= fixedCodes[i];
			clks(8);
			startPin <= 1'b1;
			convert(fixedCodes[i], 1'b1);
			clks(8);
		end
		mask = (29'(rnd() & rnd()) | 29'h1) & ~29'h4000000;
		channelEnable <= mask;
		muxModeSelect <= 1'b0;
		clks(4);
		ch = 5'h1c;
		startPin <= 1'b1;
		for (int k = 0; k < $countones(mask) + 2; k++) begin
			ch = nextEn(ch, mask);
			convert(ch, k == $countones(mask) + 1);
		end
		clks(10);
		check("pending", 32'(expCmd.size() + expWord.size() + expMux.size()), 32'h0);
		give_verdict();
	end
endmodule : tb

`default_nettype wire
